// ### design/cmsfc_pkg.sv
// Package: constants and types of the clock mode select block
package cmsfc_pkg;

	// ==========================================================
	// Modes
	typedef enum logic [1:0] {
		CMSFC_SELF_CLOCKED = 2'h0,
		CMSFC_ENGAGED_INT = 2'h1,
		CMSFC_BYPASS_EXT = 2'h2,
		CMSFC_ENGAGED_EXT = 2'h3
	} cmsfc_mode_e;

	// ==========================================================
	// Reset values and timing
	localparam logic [1:0] CMSFC_MODE_RST = 2'h0;
	localparam int CMSFC_SETTLE_CYCLES = 4;
	localparam int CMSFC_IRC_DIV = 7;
	localparam int CMSFC_CNT_W = 3;
	localparam int CMSFC_FIX_RATIO_MIN = 4;
	localparam int CMSFC_FLD_W = 3;
	localparam int CMSFC_RED_W = 8;

endpackage : cmsfc_pkg

// ### design/cmsfc_clk_div.sv
// Module: enable divider, one pulse each div_i cycles with en_i high
module cmsfc_clk_div
	import cmsfc_pkg::*;
#(
	parameter int WIDTH = 9
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic [WIDTH-1:0] div_i,
	output logic pulse_o
);

	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] cnt_next;
	logic pulse_reg;
	logic pulse_next;

	always_comb begin
		cnt_next = cnt_reg;
		pulse_next = 1'b0;
		if (en_i) begin
			if (cnt_reg + WIDTH'(1) >= div_i) begin
				cnt_next = '0;
				pulse_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			pulse_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			pulse_reg <= pulse_next;
		end
	end

	assign pulse_o = pulse_reg;

endmodule // cmsfc_clk_div

// ### design/cmsfc_mode_ctrl.sv
// Module: clock mode select, main and fixed clock enables
// Behaviour
// R1: A two-bit mode request is accepted and the mode in effect is reported apart, 00 self, 01 int, 10 bypass, 11 ext.
// R2: When the requested mode's entry conditions hold the actual mode becomes the request.
// R3: Missing flags hold the actual mode off the request; bypass to ext is barred while loss of clock is set.
// R4: The actual mode changes only several cycles after a request write, never in the same cycle.
// R5: Software wanting a crystal sets reference select 1 and request 1x on its first control write.
// R6: A first control write with reference select 0 locks it at 0 and keeps the amplifier off until reset.
// R7: Self-clocked output is osc clock over reduction, while the ring reference over 7 still feeds stability.
// R8: Engaged-ext output is osc over twice reduction while locking or relocking after a multiplier change, else over reduction.
// R9: The fixed clock equals the bus clock outside engaged-ext mode unless switched off.
// R10: In engaged-ext the fixed clock is ext ref over 2 only when P*N/R is at least 4 and locked, else bus clock.
// R11: The fixed clock is off in engaged-int and self-clocked modes; peripherals must not use it there.
// R12: High gain select 1 picks the high-gain oscillator in both ranges, 0 the low-power one.
// R13: High gain takes effect only when reference select is 1.
// R14: High gain select takes a single write after reset and ignores later ones.
// R15: Power: int runs ring and osc; ext stops ring runs osc; self stops ring runs osc open loop; bypass stops both.
// R16: Oscillator-stable and ext-reference-ok flags are status inputs to mode selection.
// R17: While request and actual differ the main output follows the actual mode without glitch.
module cmsfc_mode_ctrl
	import cmsfc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ctrl_wr_i,
	input wire logic [1:0] mode_request_field_i,
	input wire logic osc_reference_select_i,
	input wire logic high_gain_select_i,
	input wire logic range_i,
	input wire logic [CMSFC_FLD_W-1:0] multiplier_field_i,
	input wire logic [CMSFC_FLD_W-1:0] reduction_field_i,
	input wire logic osc_stable_flag_i,
	input wire logic ext_reference_ok_flag_i,
	input wire logic loss_of_clock_flag_i,
	input wire logic lock_flag_i,
	input wire logic osc_clock_i,
	input wire logic ext_reference_clock_i,
	input wire logic int_reference_clock_i,
	output logic [1:0] mode_actual_field_o,
	output logic [1:0] mode_request_o,
	output logic osc_reference_lock_o,
	output logic high_gain_o,
	output logic main_clock_en_o,
	output logic fixed_freq_clock_en_o,
	output logic fixed_freq_off_o,
	output logic int_ref_tick_o,
	output logic ring_ref_run_o,
	output logic digital_osc_run_o,
	output logic digital_osc_open_loop_o,
	output logic osc_amp_en_o
);

	// ==========================================================
	// Input synchronisers for pin-side flags and clocks
	localparam int NSYNC = 6;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] s1_reg;
	logic [NSYNC-1:0] s2_reg;
	logic [NSYNC-1:0] s3_reg;
	logic osc_stable_flag;
	logic ext_reference_ok_flag;
	logic loss_of_clock_flag;
	logic lock;
	logic osc_rise;
	logic ext_rise;
	logic irc_rise;

	assign async_in = {osc_stable_flag_i, ext_reference_ok_flag_i,
		loss_of_clock_flag_i, osc_clock_i, ext_reference_clock_i,
		int_reference_clock_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	assign osc_stable_flag = s2_reg[5]; // [R16]
	assign ext_reference_ok_flag = s2_reg[4]; // [R16]
	assign loss_of_clock_flag = s2_reg[3];
	assign lock = lock_flag_i;
	assign osc_rise = s2_reg[2] & ~s3_reg[2];
	assign ext_rise = s2_reg[1] & ~s3_reg[1];
	assign irc_rise = s2_reg[0] & ~s3_reg[0];

	// ==========================================================
	// Control register one: mode request and one-shot bits
	logic first_done_reg, first_done_next;
	logic osc_reference_select_reg, osc_reference_select_next;
	logic hgo_done_reg, hgo_done_next;
	logic hgo_reg, hgo_next;
	logic [1:0] req_reg, req_next;
	logic [CMSFC_FLD_W-1:0] mfd_last_reg, mfd_last_next;

	always_comb begin
		first_done_next = first_done_reg;
		osc_reference_select_next = osc_reference_select_reg;
		hgo_done_next = hgo_done_reg;
		hgo_next = hgo_reg;
		req_next = req_reg;
		mfd_last_next = multiplier_field_i;
		if (ctrl_wr_i) begin
			req_next = mode_request_field_i; // [R1]
			if (!first_done_reg) begin
				first_done_next = 1'b1;
				osc_reference_select_next = osc_reference_select_i; // [R6]
			end
			if (!hgo_done_reg) begin
				hgo_done_next = 1'b1;
				hgo_next = high_gain_select_i; // [R12] [R14]
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_done_reg <= 1'b0;
			osc_reference_select_reg <= 1'b0;
			hgo_done_reg <= 1'b0;
			hgo_reg <= 1'b0;
			req_reg <= CMSFC_MODE_RST;
			mfd_last_reg <= '0;
		end else begin
			first_done_reg <= first_done_next;
			osc_reference_select_reg <= osc_reference_select_next;
			hgo_done_reg <= hgo_done_next;
			hgo_reg <= hgo_next;
			req_reg <= req_next;
			mfd_last_reg <= mfd_last_next;
		end
	end

	// ==========================================================
	// Actual mode selection with settling delay
	cmsfc_mode_e act_reg, act_next;
	logic [CMSFC_CNT_W-1:0] settle_reg, settle_next;
	logic relock_reg, relock_next;
	logic entry_ok;

	always_comb begin
		case (cmsfc_mode_e'(req_reg))
			CMSFC_SELF_CLOCKED: entry_ok = 1'b1;
			CMSFC_ENGAGED_INT: entry_ok = osc_stable_flag;
			CMSFC_BYPASS_EXT: entry_ok = ext_reference_ok_flag;
			CMSFC_ENGAGED_EXT: entry_ok = osc_stable_flag & ext_reference_ok_flag &
				!(act_reg == CMSFC_BYPASS_EXT && loss_of_clock_flag);
			default: entry_ok = 1'b0;
		endcase
	end // [R3]

	always_comb begin
		act_next = act_reg;
		settle_next = settle_reg;
		relock_next = relock_reg;
		// Restart the wait on every write so status never tracks the write
		if (ctrl_wr_i) begin
			settle_next = CMSFC_CNT_W'(CMSFC_SETTLE_CYCLES); // [R4]
		end else if (settle_reg != '0) begin
			settle_next = settle_reg - CMSFC_CNT_W'(1);
		end else if (entry_ok && act_reg != cmsfc_mode_e'(req_reg)) begin
			act_next = cmsfc_mode_e'(req_reg); // [R2]
			if (act_next == CMSFC_ENGAGED_EXT) begin
				relock_next = 1'b1;
			end
		end
		if (multiplier_field_i != mfd_last_reg) begin
			relock_next = 1'b1;
		end else if (lock) begin
			relock_next = 1'b0; // [R8]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_reg <= cmsfc_mode_e'(CMSFC_MODE_RST);
			settle_reg <= '0;
			relock_reg <= 1'b1;
		end else begin
			act_reg <= act_next;
			settle_reg <= settle_next;
			relock_reg <= relock_next;
		end
	end

	// ==========================================================
	// Clock enables: main from dividers, fixed clock per mode
	logic [CMSFC_RED_W:0] red_div;
	logic main_src;
	logic main_tick;
	logic ext_half_reg, ext_half_next;
	logic [7:0] pn;
	logic ratio_ok;
	logic irc_tick;

	assign red_div = (CMSFC_RED_W+1)'(1) << (reduction_field_i +
		((act_reg == CMSFC_ENGAGED_EXT && relock_reg) ? 1 : 0)); // [R8]
	// Source follows the actual mode, so a pending request cannot glitch it
	assign main_src = (act_reg == CMSFC_BYPASS_EXT) ?
		ext_rise : osc_rise; // [R17]

	cmsfc_clk_div #(.WIDTH(CMSFC_RED_W+1)) u_main_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(main_src),
		.div_i(red_div),
		.pulse_o(main_tick)
	); // [R7]

	cmsfc_clk_div #(.WIDTH(3)) u_irc_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(irc_rise),
		.div_i(3'(CMSFC_IRC_DIV)),
		.pulse_o(irc_tick)
	); // [R7]

	// N = 4 + 2*mfd; P = 64 in low range, 1 in high range
	assign pn = 8'(4) + {4'h0, multiplier_field_i, 1'b0};
	assign ratio_ok = range_i ?
		((16'(pn) >> reduction_field_i) >= 16'(CMSFC_FIX_RATIO_MIN)) :
		(((16'(pn) << 6) >> reduction_field_i) >=
			16'(CMSFC_FIX_RATIO_MIN)); // [R10]

	always_comb begin
		ext_half_next = ext_half_reg;
		if (ext_rise) begin
			ext_half_next = ~ext_half_reg;
		end
	end

	logic main_en_reg, fix_en_reg, fix_off_reg, irc_tick_reg;
	logic main_en_next, fix_en_next, fix_off_next;

	always_comb begin
		main_en_next = main_tick;
		fix_off_next = (act_reg == CMSFC_ENGAGED_INT) ||
			(act_reg == CMSFC_SELF_CLOCKED); // [R11]
		if (fix_off_next) begin
			fix_en_next = 1'b0;
		end else if (act_reg == CMSFC_ENGAGED_EXT && ratio_ok && lock) begin
			fix_en_next = ext_rise & ext_half_reg; // [R10]
		end else begin
			fix_en_next = main_tick; // [R9]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_half_reg <= 1'b0;
			main_en_reg <= 1'b0;
			fix_en_reg <= 1'b0;
			fix_off_reg <= 1'b1;
			irc_tick_reg <= 1'b0;
		end else begin
			ext_half_reg <= ext_half_next;
			main_en_reg <= main_en_next;
			fix_en_reg <= fix_en_next;
			fix_off_reg <= fix_off_next;
			irc_tick_reg <= irc_tick;
		end
	end

	// ==========================================================
	// Power and oscillator controls, registered
	logic ring_reg, dosc_reg, open_reg, amp_reg, hg_eff_reg;
	logic ref_lock_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ring_reg <= 1'b0;
			dosc_reg <= 1'b1;
			open_reg <= 1'b1;
			amp_reg <= 1'b0;
			hg_eff_reg <= 1'b0;
			ref_lock_reg <= 1'b0;
		end else begin
			ref_lock_reg <= first_done_reg & ~osc_reference_select_reg; // [R6]
			ring_reg <= (act_reg == CMSFC_ENGAGED_INT); // [R15]
			dosc_reg <= (act_reg != CMSFC_BYPASS_EXT); // [R15]
			open_reg <= (act_reg == CMSFC_SELF_CLOCKED); // [R15]
			amp_reg <= osc_reference_select_reg; // [R6]
			hg_eff_reg <= hgo_reg & osc_reference_select_reg; // [R13]
		end
	end

	assign mode_actual_field_o = act_reg; // [R1]
	assign mode_request_o = req_reg;
	assign osc_reference_lock_o = ref_lock_reg;
	assign high_gain_o = hg_eff_reg;
	assign main_clock_en_o = main_en_reg;
	assign fixed_freq_clock_en_o = fix_en_reg;
	assign fixed_freq_off_o = fix_off_reg;
	assign int_ref_tick_o = irc_tick_reg;
	assign ring_ref_run_o = ring_reg;
	assign digital_osc_run_o = dosc_reg;
	assign digital_osc_open_loop_o = open_reg;
	assign osc_amp_en_o = amp_reg;

endmodule // cmsfc_mode_ctrl

// ### testbench/cmsfc_properties.sv
// Checker of the clock mode select block
module cmsfc_checker
	import cmsfc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ctrl_wr_i,
	input wire logic [1:0] mode_request_field_i,
	input wire logic osc_stable_flag_i,
	input wire logic ext_reference_ok_flag_i,
	input logic [1:0] mode_actual_field_o,
	input logic [1:0] mode_request_o,
	input logic osc_reference_lock_o,
	input logic high_gain_o,
	input logic fixed_freq_clock_en_o,
	input logic fixed_freq_off_o,
	input logic ring_ref_run_o,
	input logic digital_osc_run_o,
	input logic osc_amp_en_o
);
	// ====================
	// Sequences
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_write;
		ctrl_wr_i;
	endsequence
	sequence s_settle;
		$stable(mode_actual_field_o) [*4];
	endsequence
	// ====================
	// Properties
	a_req_echo: assert property (
		s_write |=> mode_request_o == $past(mode_request_field_i))
		else $error("request not stored");
	a_mode_settle: assert property (s_write |=> s_settle)
		else $error("mode changed too soon after write");
	a_int_needs_stable: assert property (
		$changed(mode_actual_field_o) && mode_actual_field_o == 2'h1
		|-> $past(osc_stable_flag_i, 3))
		else $error("engaged internal without stable flag");
	a_bypass_needs_ok: assert property (
		$changed(mode_actual_field_o) && mode_actual_field_o == 2'h2
		|-> $past(ext_reference_ok_flag_i, 3))
		else $error("bypass entered without reference ok");
	a_fixed_off_mode: assert property (
		fixed_freq_off_o == !$past(mode_actual_field_o[1]))
		else $error("fixed clock off state wrong");
	a_fixed_quiet_off: assert property (
		fixed_freq_off_o |-> !fixed_freq_clock_en_o)
		else $error("fixed clock pulses while off");
	a_ring_power: assert property (
		ring_ref_run_o == ($past(mode_actual_field_o) == 2'h1))
		else $error("ring reference power wrong");
	a_osc_power: assert property (
		digital_osc_run_o == ($past(mode_actual_field_o) != 2'h2))
		else $error("oscillator power wrong");
	a_ref_lock_hold: assert property (
		osc_reference_lock_o |=> osc_reference_lock_o && !osc_amp_en_o)
		else $error("reference lock released");
	a_gain_needs_ref: assert property (high_gain_o |-> osc_amp_en_o)
		else $error("high gain without reference select");
endmodule // cmsfc_checker

bind cmsfc_mode_ctrl cmsfc_checker u_chk (.*);

// ### testbench/cmsfc_mode_ctrl_test.sv
// Testbench of the clock mode select block
module cmsfc_mode_ctrl_test
	import cmsfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ====================
	// Signals
	logic clk_i = 0, rst_i = 1, wr = 0, osc_reference_select = 0, high_gain_select = 0;
	logic osc_stable_flag = 0, erok = 0, loc = 0, lock = 0;
	logic oclk = 0, eclk = 0, iclk = 0;
	logic [1:0] req = 2'h0;
	logic rng = 1'b1;
	logic [2:0] multiplier_field = 3'h0, reduction_field = 3'h0;
	logic [1:0] act, rq;
	logic lk, hg, men, fen, foff, tick, ring, drun, open, amp;
	int fails = 0, n_compared = 0, cyc = 0, nm = 0, nf = 0, nt = 0;
	always #5 clk_i = ~clk_i;
	// Slow source clocks stay well under a quarter of the bus rate
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		nm <= nm + men;
		nf <= nf + fen;
		nt <= nt + tick;
		if (cyc % 4 == 3) oclk <= ~oclk;
		if (cyc % 6 == 5) eclk <= ~eclk;
		if (cyc % 5 == 4) iclk <= ~iclk;
		if (cyc == 5000) begin
			fails++;
			give_verdict();
		end
	end
	cmsfc_mode_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ctrl_wr_i(wr),
		.mode_request_field_i(req), .osc_reference_select_i(osc_reference_select),
		.high_gain_select_i(high_gain_select), .range_i(rng),
		.multiplier_field_i(multiplier_field), .reduction_field_i(reduction_field),
		.osc_stable_flag_i(osc_stable_flag), .ext_reference_ok_flag_i(erok),
		.loss_of_clock_flag_i(loc), .lock_flag_i(lock),
		.osc_clock_i(oclk), .ext_reference_clock_i(eclk),
		.int_reference_clock_i(iclk), .mode_actual_field_o(act),
		.mode_request_o(rq), .osc_reference_lock_o(lk),
		.high_gain_o(hg), .main_clock_en_o(men),
		.fixed_freq_clock_en_o(fen), .fixed_freq_off_o(foff),
		.int_ref_tick_o(tick), .ring_ref_run_o(ring),
		.digital_osc_run_o(drun), .digital_osc_open_loop_o(open),
		.osc_amp_en_o(amp));
	// ====================
	// Tasks
	task automatic chk(string what, logic [1:0] exp, logic [1:0] got);
		#1;
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_ctrl(logic [1:0] r, logic s, logic g);
		@(posedge clk_i);
		wr <= 1'b1;
		req <= r;
		osc_reference_select <= s;
		high_gain_select <= g;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic idle(int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wait_mode(logic [1:0] m);
		for (int i = 0; i < 60 && act !== m; i++) begin
			@(posedge clk_i);
			#1;
		end
		chk("mode", m, act);
	endtask
	task automatic give_verdict();
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ====================
	// Tests
	initial begin
		int k, d;
		idle(16);
		rst_i <= 1'b0;
		chk("mode", 2'h0, act);
		chk("fixed_off", 1, foff);
		wr_ctrl(2'h2, 1'b1, 1'b1);
		idle(40);
		chk("mode", 2'h0, act);
		chk("request", 2'h2, rq);
		chk("high_gain", 1, hg);
		chk("amp", 1, amp);
		@(posedge clk_i) erok <= 1'b1;
		wait_mode(2'h2);
		idle(3);
		chk("ring", 0, ring);
		chk("osc_run", 0, drun);
		k = nf;
		idle(48);
		chk("fixed_run", 1, nf > k);
		@(posedge clk_i) loc <= 1'b1;
		osc_stable_flag <= 1'b1;
		wr_ctrl(2'h3, 1'b0, 1'b0);
		idle(40);
		chk("mode", 2'h2, act);
		chk("high_gain", 1, hg);
		@(posedge clk_i) loc <= 1'b0;
		wait_mode(2'h3);
		idle(3);
		chk("osc_run", 1, drun);
		k = nm;
		idle(96);
		chk("main_relock", 1, (nm - k) inside {[5:7]});
		@(posedge clk_i) lock <= 1'b1;
		idle(8);
		k = nm;
		d = nf;
		idle(96);
		chk("main_locked", 1, (nm - k) inside {[11:13]});
		chk("fixed_ext", 1, (nf - d) inside {[3:5]});
		// Ratio 4/2 falls below the minimum, so fixed follows the bus clock
		@(posedge clk_i) reduction_field <= 3'h1;
		idle(8);
		k = nm;
		d = nf;
		idle(96);
		chk("main_red", 1, (nm - k) inside {[5:7]});
		chk("fixed_bus", 1, (nf - d) == (nm - k));
		@(posedge clk_i) rng <= 1'b0;
		idle(8);
		d = nf;
		idle(96);
		chk("fixed_low", 1, (nf - d) inside {[3:5]});
		@(posedge clk_i) multiplier_field <= 3'h1;
		lock <= 1'b0;
		idle(8);
		k = nm;
		idle(96);
		chk("main_mfd", 1, (nm - k) inside {[2:4]});
		wr_ctrl(2'h1, 1'b0, 1'b0);
		wait_mode(2'h1);
		idle(2);
		chk("ring", 1, ring);
		chk("fixed_off", 1, foff);
		k = nf;
		idle(40);
		chk("fixed_quiet", 1, nf == k);
		wr_ctrl(2'h0, 1'b0, 1'b0);
		wait_mode(2'h0);
		idle(2);
		chk("open_loop", 1, open);
		k = nt;
		idle(150);
		chk("ref_tick", 1, (nt - k) inside {[1:3]});
		@(posedge clk_i) rst_i <= 1'b1;
		idle(16);
		rst_i <= 1'b0;
		wr_ctrl(2'h0, 1'b0, 1'b1);
		idle(2);
		chk("ref_lock", 1, lk);
		chk("high_gain", 0, hg);
		wr_ctrl(2'h2, 1'b1, 1'b1);
		idle(2);
		chk("amp", 0, amp);
		give_verdict();
	end
endmodule // cmsfc_mode_ctrl_test
